// >>> sim/fic_counter_chk.sv
`timescale 1ns/1ps
module fic_counter_chk
    import fic_pkg::*;
#(
    parameter logic [2:0] COUNTER_ENABLE = 3'h5
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic stop_count,
    input wire logic [7:0] enable_n,
    input wire logic [7:0] select_n,
    input wire logic [3:0] data_latch,
    input wire logic ramp_start,
    input wire fic_carry_t carry
);
    logic wr_q;
    fic_code_t code_q;
    logic [7:0] en_exp;

    // Shadow of the last port code written
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_q <= 1'b0;
            code_q <= IBUS_RESET;
        end
        else if (hready)
        begin
            wr_q <= hsel && htrans[1] && hwrite && haddr[7:0] == REG_IBUS;
            if (wr_q)
            begin
                code_q <= hwdata[11:0];
            end
        end
    end
    assign en_exp = code_q.e[3] ? 8'hff : ~(8'h01 << code_q.e[2:0]);

    property p_en_dec;
        @(posedge hclk) disable iff (!hresetn) enable_n == $past(en_exp);
    endproperty
    a_en_dec: assert property (p_en_dec) else $error("enable decode wrong");
    property p_sel_en;
        @(posedge hclk) disable iff (!hresetn) select_n != 8'hff |-> !enable_n[COUNTER_ENABLE];
    endproperty
    a_sel_en: assert property (p_sel_en) else $error("select without enable");
    property p_sel_code;
        @(posedge hclk) disable iff (!hresetn) select_n != 8'hff |->
            $past(code_q.s[3]) && select_n == ~(8'h01 << ~$past(code_q.s[2:0]));
    endproperty
    a_sel_code: assert property (p_sel_code) else $error("select code wrong");
    property p_sel_pulse;
        @(posedge hclk) disable iff (!hresetn) select_n != 8'hff |=> select_n == 8'hff;
    endproperty
    a_sel_pulse: assert property (p_sel_pulse) else $error("select too long");
    property p_latch;
        @(posedge hclk) disable iff (!hresetn)
            !$stable(data_latch) |-> !$past(select_n[0]) || !$past(select_n[0], 2);
    endproperty
    a_latch: assert property (p_latch) else $error("latch without trigger");
    property p_carry;
        @(posedge hclk) disable iff (!hresetn) carry.cycle || carry.clock |=> carry == 2'b00;
    endproperty
    a_carry: assert property (p_carry) else $error("carry too long");
    property p_bus;
        @(posedge hclk) disable iff (!hresetn) hreadyout && !hresp;
    endproperty
    a_bus: assert property (p_bus) else $error("bus response wrong");
    property p_stop;
        @(posedge hclk) disable iff (!hresetn) ramp_start && stop_count |-> ##[1:4] !ramp_start;
    endproperty
    a_stop: assert property (p_stop) else $error("stop ignored");
endmodule

bind fic_counter fic_counter_chk #(.COUNTER_ENABLE(COUNTER_ENABLE)) i_fic_counter_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .stop_count(stop_count), .enable_n(enable_n), .select_n(select_n),
    .data_latch(data_latch), .ramp_start(ramp_start), .carry(carry)
);

// >>> sim/fic_src_model.sv
`timescale 1ns/1ps
module fic_src_model
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic rise_req,
    input wire logic ramp_start,
    input wire logic [15:0] stop_dly,
    output logic selected_input_frequency,
    output logic stop_count
);
    logic [2:0] hi_q;
    logic [15:0] ramp_q;

    // One input cycle per request; one stop pulse per ramp
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hi_q <= 3'h0;
            ramp_q <= 16'h0;
            stop_count <= 1'b0;
        end
        else
        begin
            hi_q <= rise_req ? 3'h4 : (hi_q != 3'h0 ? hi_q - 3'h1 : 3'h0);
            ramp_q <= ramp_start ? ramp_q + 16'h1 : 16'h0;
            stop_count <= ramp_start && ramp_q == stop_dly;
        end
    end
    assign selected_input_frequency = hi_q != 3'h0;
endmodule

// >>> sim/tb_fic_counter.sv
`timescale 1ns/1ps
module tb_fic_counter;
    import fic_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, sig, stop, ramp, rise_req;
    logic [31:0] haddr, hwdata, hrdata, v;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] enable_n, select_n, e8;
    logic [3:0] data_latch, readback_data;
    logic [15:0] stop_dly, cnt;
    fic_carry_t carry;
    int err_total, check_count;

    assign hready = hreadyout;
    fic_counter i_fic_counter (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .selected_input_frequency(sig),
        .stop_count(stop), .enable_n(enable_n), .select_n(select_n), .data_latch(data_latch),
        .ramp_start(ramp), .carry(carry), .readback_data(readback_data));
    fic_src_model i_fic_src_model (.hclk(hclk), .hresetn(hresetn), .rise_req(rise_req),
        .ramp_start(ramp), .stop_dly(stop_dly), .selected_input_frequency(sig),
        .stop_count(stop));

    initial
    begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end

    task automatic final_report;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
        begin
            $display("Run complete: PASS");
        end
        else
        begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chkr(input logic [31:0] got, input int lo, input int hi);
        check_count++;
        if ($isunknown(got) || got < lo || got > hi)
        begin
            err_total++;
            $display("[FAIL] %0t got %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask

    // Single AHB transfer, waits on hready in both phases
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        v = hrdata;
    endtask

    task automatic ibus(input logic [3:0] e, input logic [3:0] s, input logic [3:0] d);
        ahb(1'b1, REG_IBUS, {20'h0, e, s, d});
        repeat (4) @(posedge hclk);
    endtask

    task automatic rise;
        @(posedge hclk);
        rise_req <= 1'b1;
        @(posedge hclk);
        rise_req <= 1'b0;
        repeat (18) @(posedge hclk);
    endtask

    task automatic chain(input logic [15:0] c);
        logic [3:0] exp [5];
        exp = '{c[14:11], {3'h0, c[15]}, {1'b0, c[10:8]}, c[7:4], c[3:0]};
        for (int i = 0; i < 5; i++)
        begin
            if (i > 0) ibus(4'h5, 4'he, 4'h0);
            ahb(1'b0, REG_RDBK, 32'h0);
            chk(v[3:0], exp[i]);
            chk(readback_data, exp[i]);
        end
    endtask

    initial
    begin
        int n;
        hresetn = 1'b0;
        {hsel, hwrite, rise_req, haddr, hwdata, htrans} = '0;
        hsize = 3'h2;
        stop_dly = 16'd21000;
        err_total = 0;
        check_count = 0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, REG_STAT, 32'h0);
        chk(v, 32'h0);
        ahb(1'b0, 8'h10, 32'h0);
        chk(v, 32'h0);
        ahb(1'b1, REG_STAT, 32'hffff_ffff);
        ahb(1'b0, REG_STAT, 32'h0);
        chk(v, 32'h0);
        for (int k = 0; k < 16; k++)
        begin
            ibus(4'(k), 4'h7, 4'h6);
            e8 = ~(8'h01 << k);
            chk(enable_n, k > 7 ? 8'hff : e8);
        end
        ibus(4'h4, 4'hf, 4'h6);
        ahb(1'b0, REG_STAT, 32'h0);
        chk({data_latch, v[2:0]}, 7'h00);
        ibus(4'h5, 4'hf, 4'h6);
        chk(data_latch, 4'h6);
        ahb(1'b0, REG_STAT, 32'h0);
        chk(v[6:0], 7'h01);
        rise();
        ahb(1'b0, REG_STAT, 32'h0);
        chk(v[6:0], 7'h43);
        for (int k = 0; k < 32; k++) rise();
        ibus(4'h5, 4'hf, 4'h0);
        ahb(1'b0, REG_STAT, 32'h0);
        chk(v[2:0], 3'h2);
        rise();
        ahb(1'b0, REG_STAT, 32'h0);
        chk(v[23:0], 24'h010006);
        ahb(1'b0, REG_CNT, 32'h0);
        cnt = v[15:0];
        chk(cnt[15:11], 5'h01);
        chkr(cnt[10:0], 60, 72);
        chain(cnt);
        ibus(4'h5, 4'hf, 4'h1);
        ahb(1'b0, REG_STAT, 32'h0);
        chk(v[4], 1'b1);
        ibus(4'h5, 4'hf, 4'hb);
        chk(ramp, 1'b1);
        repeat (20) @(posedge hclk);
        ahb(1'b0, REG_STAT, 32'h0);
        chk(v[2:0], 3'h5);
        n = 0;
        while (ramp === 1'b1 && n < 30000)
        begin
            @(posedge hclk);
            n++;
        end
        ahb(1'b0, REG_STAT, 32'h0);
        chk(v[23:0], 24'h000116);
        ahb(1'b0, REG_CNT, 32'h0);
        cnt = v[15:0];
        chk(cnt[15:11], 5'h00);
        chkr(cnt[10:0], 49, 55);
        chain(cnt);
        final_report();
    end

    // Whole run is about 22000 cycles
    initial
    begin
        repeat (40000) @(posedge hclk);
        err_total++;
        final_report();
    end
endmodule

// >>> verilog/fic_counter.sv
`timescale 1ns/1ps
module fic_counter
    import fic_pkg::*;
#(
    parameter logic [2:0] COUNTER_ENABLE = 3'h5
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic selected_input_frequency,
    input wire logic stop_count,
    output logic [7:0] enable_n,
    output logic [7:0] select_n,
    output logic [3:0] data_latch,
    output logic ramp_start,
    output fic_carry_t carry,
    output logic [3:0] readback_data
);

    function automatic logic [7:0] dec3(input logic [2:0] v);
        dec3 = 8'h01 << v;
    endfunction

    // AHB-Lite slave, zero wait states
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic [31:0] hrdata_q;
    logic acc;
    logic [31:0] rd_mux;

    assign acc = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            wr_pend_q <= 1'b0;
        else
            wr_pend_q <= acc && hwrite;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            wr_addr_q <= 8'h00;
        else
            wr_addr_q <= haddr[7:0];
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata_q <= 32'h0000_0000;
        else if (acc && !hwrite)
            hrdata_q <= rd_mux;
    end

    // Instrument bus code as written to the processor port
    fic_code_t port_q;
    logic strobe_q;
    logic [3:0] bus_s;
    logic dec_en;
    logic [7:0] en_d;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            port_q <= IBUS_RESET;
        else if (wr_pend_q && wr_addr_q == REG_IBUS)
            port_q <= hwdata[11:0];
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            strobe_q <= 1'b0;
        else
            strobe_q <= wr_pend_q && wr_addr_q == REG_IBUS;
    end

    assign bus_s = ~port_q.s;
    assign dec_en = !port_q.e[3];
    // Select qualifies on the enable of the code just written
    assign en_d = dec_en ? ~dec3(port_q.e[2:0]) : 8'hff;

    // Enable lines follow the port; select lines pulse once per write that enables the select decoder
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            enable_n <= 8'hff;
        else
            enable_n <= en_d;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            select_n <= 8'hff;
        else if (strobe_q && !bus_s[3] && !en_d[COUNTER_ENABLE])
            select_n <= ~dec3(bus_s[2:0]);
        else
            select_n <= 8'hff;
    end

    logic ctrl_trig;
    logic xfer_trig;
    assign ctrl_trig = !select_n[SEL_CTRL];
    assign xfer_trig = !select_n[SEL_XFER];

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            data_latch <= 4'h0;
        else if (ctrl_trig)
            data_latch <= port_q.d;
    end

    logic do_clear;
    logic do_arm;
    logic do_disarm;
    logic do_ivarm;
    logic tb_sel_q;
    logic fr_start;
    logic iv_start;
    assign do_clear = ctrl_trig && port_q.d[CB_CLEAR];
    assign do_arm = ctrl_trig && port_q.d[CB_ARM];
    assign do_disarm = ctrl_trig && !port_q.d[CB_ARM];
    assign do_ivarm = ctrl_trig && port_q.d[CB_IVARM];
    assign fr_start = do_arm && !port_q.d[CB_TBSEL];
    assign iv_start = do_ivarm && port_q.d[CB_TBSEL];

    // Time-base path selector: 0 frequency gate, 1 interval gate
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            tb_sel_q <= 1'b0;
        else if (ctrl_trig)
            tb_sel_q <= port_q.d[CB_TBSEL];
    end

    // 2 MHz time-base tick
    logic [$clog2(TB_DIV)-1:0] div_q;
    logic tick;
    assign tick = div_q == ($clog2(TB_DIV))'(TB_DIV - 1);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            div_q <= '0;
        else if (tick)
            div_q <= '0;
        else
            div_q <= div_q + 1'b1;
    end

    // Input cycle start detection
    logic fin_prev_q;
    logic fin_rise;
    assign fin_rise = selected_input_frequency && !fin_prev_q;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            fin_prev_q <= 1'b0;
        else
            fin_prev_q <= selected_input_frequency;
    end

    // Mode selector and interval gate
    fic_state_t state_q;
    logic end_gate;
    assign end_gate = (state_q == FIC_DISARM && fin_rise)
        || (state_q == FIC_IV_COUNT && stop_count);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            state_q <= FIC_IDLE;
        else
        begin
            unique case (state_q)
                FIC_IDLE, FIC_DONE:
                begin
                    if (fr_start)
                        state_q <= FIC_ARMED;
                    else if (iv_start)
                        state_q <= FIC_IV_ARMED;
                end
                FIC_ARMED:
                begin
                    if (do_disarm)
                        state_q <= FIC_IDLE;
                    else if (fin_rise)
                        state_q <= FIC_GATING;
                end
                FIC_GATING:
                begin
                    if (do_disarm)
                        state_q <= FIC_DISARM;
                end
                FIC_DISARM:
                begin
                    if (fin_rise)
                        state_q <= FIC_DONE;
                end
                FIC_IV_ARMED:
                begin
                    if (tick)
                        state_q <= FIC_IV_COUNT;
                end
                FIC_IV_COUNT:
                begin
                    if (stop_count)
                        state_q <= FIC_DONE;
                end
                default:
                    state_q <= FIC_IDLE;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ramp_start <= 1'b0;
        else if (iv_start && (state_q == FIC_IDLE || state_q == FIC_DONE))
            ramp_start <= 1'b1;
        else if (end_gate || state_q == FIC_IDLE)
            ramp_start <= 1'b0;
    end

    // Gates: cycle counter only in frequency mode
    logic freq_gate;
    logic cyc_en;
    logic tb_en;
    assign freq_gate = state_q == FIC_GATING || state_q == FIC_DISARM;
    assign cyc_en = freq_gate && fin_rise;
    assign tb_en = tick && ((freq_gate && !tb_sel_q)
        || (state_q == FIC_IV_COUNT && tb_sel_q));

    // Counters and final-stage carries
    logic [CYC_W-1:0] cyc_q;
    logic [TBC_W-1:0] tbc_q;
    logic [7:0] tb_car_q;
    logic [7:0] cyc_car_q;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cyc_q <= '0;
        else if (do_clear)
            cyc_q <= '0;
        else if (cyc_en)
            cyc_q <= cyc_q + 1'b1;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            tbc_q <= '0;
        else if (do_clear)
            tbc_q <= '0;
        else if (tb_en)
            tbc_q <= tbc_q + 1'b1;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            carry <= '0;
        else if (do_clear)
            carry <= '0;
        else
        begin
            carry.cycle <= cyc_en && (&cyc_q);
            carry.clock <= tb_en && (&tbc_q);
        end
    end

    // Carry gating: each carry pulse counted a cycle later, whether gates are open or closed
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tb_car_q <= 8'h00;
            cyc_car_q <= 8'h00;
        end
        else if (do_clear)
        begin
            tb_car_q <= 8'h00;
            cyc_car_q <= 8'h00;
        end
        else
        begin
            if (carry.clock)
                tb_car_q <= tb_car_q + 1'b1;
            if (carry.cycle)
                cyc_car_q <= cyc_car_q + 1'b1;
        end
    end

    // Transfer chain, lowest nibble is cycle stage 1
    logic [STAGES*NIB-1:0] chain_q;
    logic load_q;

    // Stage order seen by the controller, lowest nibble first
    function automatic logic [STAGES*NIB-1:0] pack_stages(input logic [CYC_W-1:0] c,
        input logic [TBC_W-1:0] t);
        pack_stages = {t[3:0], t[7:4], 1'b0, t[10:8], 3'b000, c[4], c[3:0]};
    endfunction

    // Load a cycle after the gate opens, once the closing count has landed
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            load_q <= 1'b0;
        else
            load_q <= end_gate;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            chain_q <= '0;
        else if (do_clear)
            chain_q <= '0;
        else if (load_q)
            chain_q <= pack_stages(cyc_q, tbc_q);
        else if (xfer_trig && state_q == FIC_DONE)
            chain_q <= {{NIB{1'b0}}, chain_q[STAGES*NIB-1:NIB]};
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            readback_data <= 4'h0;
        else
            readback_data <= chain_q[NIB-1:0];
    end

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (haddr[7:0])
            REG_IBUS: rd_mux[11:0] = port_q;
            REG_STAT:
            begin
                rd_mux[ST_STATE +: 3] = state_q;
                rd_mux[ST_TBSEL] = tb_sel_q;
                rd_mux[ST_RAMP] = ramp_start;
                rd_mux[ST_GATE] = freq_gate;
                rd_mux[ST_TBCAR +: 8] = tb_car_q;
                rd_mux[ST_CYCAR +: 8] = cyc_car_q;
            end
            REG_RDBK: rd_mux[3:0] = chain_q[NIB-1:0];
            REG_CNT: rd_mux[CYC_W+TBC_W-1:0] = {cyc_q, tbc_q};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

endmodule

// >>> verilog/fic_pkg.sv
// Notes on behaviour
// - Cycle counter counts input periods in two stages, total ratio 32.
// - Time-base counter counts 2 MHz ticks in three stages, total ratio 2048.
// - Frequency mode uses both counters; interval mode uses only the time base.
// - Frequency mode needs interval path open and time base fed by frequency gate.
// - Armed selector closes both gates at the next input cycle start.
// - Gated counters emit final-stage carries; controller counts them via carry gating.
// - After disarm, gates open at next input cycle start; one whole cycle counted.
// - After gating, stage contents are presented, first cycle-counter stage first.
// - Each step shifts next higher stages into stage one and presents again.
// - First time-base tick after arming closes interval gate; every tick is counted.
// - Stop-count pulse ends counting; count is read stage by stage as before.
// - Three enable bits decode to eight active-low lines; fourth bit gates decoder.
// - Select and data codes are four bits each on port lines 00 to 07.
// - Select codes are decoded only while the own enable line is active.
// - Data codes are latched only on the decoded select line trigger.
// - Select bits reach the bus through inverters; low port appears high.
// - Bits numbered from 0; decoded enable index equals the enable bits value.
// - Unbuffered data lines read status or measurement values back.
// - Enable decoder is active only while enable bit 3 is low on the bus.
// - Select decoder enabled only when select bit 3 and own enable line are low.
package fic_pkg;

    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned TB_HZ = 2_000_000;
    localparam int unsigned TB_DIV = CLK_HZ / TB_HZ;

    localparam int unsigned CYC_RATIO = 32;
    localparam int unsigned TB_RATIO = 2048;
    localparam int unsigned CYC_W = $clog2(CYC_RATIO);
    localparam int unsigned TBC_W = $clog2(TB_RATIO);
    localparam int unsigned STAGES = 5;
    localparam int unsigned NIB = 4;

    // Register byte offsets
    localparam logic [7:0] REG_IBUS = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_RDBK = 8'h08;
    localparam logic [7:0] REG_CNT = 8'h0c;
    localparam logic [11:0] IBUS_RESET = 12'hfff;

    // Status field positions
    localparam int unsigned ST_STATE = 0;
    localparam int unsigned ST_TBSEL = 4;
    localparam int unsigned ST_RAMP = 5;
    localparam int unsigned ST_GATE = 6;
    localparam int unsigned ST_TBCAR = 8;
    localparam int unsigned ST_CYCAR = 16;

    // Counter select codes and control data bits
    localparam logic [2:0] SEL_CTRL = 3'h0;
    localparam logic [2:0] SEL_XFER = 3'h1;
    localparam int unsigned CB_TBSEL = 0;
    localparam int unsigned CB_CLEAR = 1;
    localparam int unsigned CB_ARM = 2;
    localparam int unsigned CB_IVARM = 3;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;

    typedef struct packed {
        logic [3:0] e;
        logic [3:0] s;
        logic [3:0] d;
    } fic_code_t;

    typedef struct packed {
        logic cycle;
        logic clock;
    } fic_carry_t;

    typedef enum logic [2:0] {
        FIC_IDLE = 3'b000,
        FIC_ARMED = 3'b001,
        FIC_GATING = 3'b011,
        FIC_DISARM = 3'b010,
        FIC_DONE = 3'b110,
        FIC_IV_ARMED = 3'b100,
        FIC_IV_COUNT = 3'b101
    } fic_state_t;

endpackage
